/* common/apm_defs.svh */
// Offsets, field positions, reset values and response codes of the
// power-management register bank. Included by the bank and by the bench.
`ifndef APM_DEFS_SVH
`define APM_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (host offset; EC byte address is four times this)
// ----------------------------------------------------------------------
`define APM_IDX_STS_LO 3'h0
`define APM_IDX_STS_HI 3'h1
`define APM_IDX_EN_LO 3'h2
`define APM_IDX_EN_HI 3'h3
`define APM_IDX_CTL_LO 3'h4
`define APM_IDX_CTL_HI 3'h5
`define APM_IDX_PM2_LO 3'h6
`define APM_IDX_PM2_HI 3'h7
`define APM_REG_COUNT 8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define APM_BIT_WAKE_STS 7
`define APM_BIT_OVR_STS 3
`define APM_BIT_ALARM_STS 2
`define APM_BIT_SLEEP_BUTTON_STATUS 1
`define APM_BIT_POWER_BUTTON_STATUS 0
`define APM_BIT_ALARM_EN 2
`define APM_BIT_SLEEP_BUTTON_ENABLE 1
`define APM_BIT_POWER_BUTTON_ENABLE 0
`define APM_BIT_SLEEP_EN 5
`define APM_SLEEP_TYPE_HI 4
`define APM_SLEEP_TYPE_LO 2
`define APM_BIT_OVR_EN 1

// ----------------------------------------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------------------------------------
`define APM_STS_MASK 8'h8F
`define APM_EN_MASK 8'h07
`define APM_STS_RESET 8'h00
`define APM_EN_RESET 8'h00
`define APM_SLEEP_TYPE_RESET 3'h0
`define APM_BIT_RESET 1'b0

// ----------------------------------------------------------------------
// AXI4-Lite response codes
// ----------------------------------------------------------------------
`define APM_RESP_OKAY 2'h0
`define APM_RESP_SLVERR 2'h2

`endif

/* common/apm_pkg.sv */
// Types shared by the power-management register bank and its bench.
// Assumes apm_defs.svh holds every number.
package apm_pkg;

    // ------------------------------------------------------------------
    // Host I/O request, one byte per access
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } apm_host_req_t;

    // ------------------------------------------------------------------
    // Controller interrupt pulses, one per host-written register
    // ------------------------------------------------------------------
    typedef struct packed {
        logic statusWritten;
        logic enableWritten;
        logic controlWritten;
    } apm_ec_irq_t;

endpackage : apm_pkg

/* design/apm_pm1_regs.sv */
// Power-management register bank shared by the system host (byte I/O
// port) and the embedded controller (AXI4-Lite slave).
// Assumes the host port is already in the clk domain, one request per
// cycle, with the block base aligned to eight bytes.
`timescale 1ns/1ps
`include "apm_defs.svh"

module apm_pm1_regs
    import apm_pkg::*;
#(
    parameter int HOST_ADDR_W = 16,
    parameter int AXI_ADDR_W = 12
)
(
    // Clock and system reset
    input wire logic clk,
    input wire logic rst_n,
    // Host I/O port
    input wire logic [HOST_ADDR_W-1:0] hostBase,
    input apm_host_req_t hostReq,
    output logic [7:0] hostRdData,
    output logic hostAck,
    // EC AXI4-Lite write address and data
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // EC AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // EC AXI4-Lite read
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Controller interrupt pulses and state seen by the rest of the chip
    output apm_ec_irq_t ecIrq,
    output logic [2:0] sleepType,
    output logic sleepEnable,
    output logic eventPending
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (HOST_ADDR_W < 4 || HOST_ADDR_W > 16)
    begin : gHostWidthCheck
        $error("HOST_ADDR_W must lie between 4 and 16");
    end
    if (AXI_ADDR_W < 6)
    begin : gAxiWidthCheck
        $error("AXI_ADDR_W must be at least 6");
    end

    // ------------------------------------------------------------------
    // Bank state
    // ------------------------------------------------------------------
    logic [7:0] status_ff;
    logic [7:0] nxt_status;
    logic [7:0] enable_ff;
    logic [2:0] sleepType_ff;
    logic overrideEnable_ff;
    logic sleepEnable_ff;
    logic nxt_sleepEnable;

    // AXI write channel holding registers
    logic awTaken_ff;
    logic [AXI_ADDR_W-1:0] awAddr_ff;
    logic wTaken_ff;
    logic [7:0] wByte_ff;
    logic wLane_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    // AXI read channel
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    // Host answer and interrupt pulses
    logic [7:0] hostRdData_ff;
    logic hostAck_ff;
    apm_ec_irq_t ecIrq_ff;

    // ------------------------------------------------------------------
    // Read view of the bank for either party
    // ------------------------------------------------------------------
    function automatic logic [7:0] readView(input logic [2:0] idx, input logic fromHost);
        logic [7:0] val;
        val = 8'h00;
        if (idx == `APM_IDX_STS_HI)
        begin
            val = status_ff & `APM_STS_MASK;
        end
        else if (idx == `APM_IDX_EN_HI)
        begin
            val = enable_ff & `APM_EN_MASK;
        end
        else if (idx == `APM_IDX_CTL_HI)
        begin
            val[`APM_SLEEP_TYPE_HI:`APM_SLEEP_TYPE_LO] = sleepType_ff;
            val[`APM_BIT_OVR_EN] = overrideEnable_ff;
            // Host always sees zero so a read-modify-write cannot re-arm
            val[`APM_BIT_SLEEP_EN] = fromHost ? 1'b0 : sleepEnable_ff;
        end
        return val;
    endfunction : readView

    // ------------------------------------------------------------------
    // Host decode
    // ------------------------------------------------------------------
    logic hostHit;
    logic [2:0] hostIdx;
    logic hostWr;
    logic hostRd;

    // Base is eight-byte aligned, so only the upper bits are compared
    assign hostHit = hostReq.addr[HOST_ADDR_W-1:3] == hostBase[HOST_ADDR_W-1:3];
    assign hostIdx = hostReq.addr[2:0];
    assign hostWr = hostReq.valid && hostReq.write && hostHit;
    assign hostRd = hostReq.valid && !hostReq.write && hostHit;

    // ------------------------------------------------------------------
    // AXI decode
    // ------------------------------------------------------------------
    logic ecWrFire;
    logic ecWrMapped;
    logic [2:0] ecWrIdx;
    logic ecWrOk;
    logic arFire;
    logic arMapped;

    // Both halves held and no response outstanding: the write lands now
    assign ecWrFire = awTaken_ff && wTaken_ff && !bvalid_ff;
    assign ecWrMapped = awAddr_ff[AXI_ADDR_W-1:5] == '0;
    assign ecWrIdx = awAddr_ff[4:2];
    // Only byte lane 0 carries a register; other lanes are dropped
    assign ecWrOk = ecWrFire && ecWrMapped && wLane_ff;
    assign arFire = s_axi_arvalid && s_axi_arready;
    assign arMapped = s_axi_araddr[AXI_ADDR_W-1:5] == '0;

    // ------------------------------------------------------------------
    // Status bits: EC write, host one-to-clear, EC wins in a tie
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_status = status_ff;
        if (hostWr && hostIdx == `APM_IDX_STS_HI)
        begin
            nxt_status = status_ff & ~(hostReq.wdata & `APM_STS_MASK);
        end
        if (ecWrOk && ecWrIdx == `APM_IDX_STS_HI)
        begin
            // Applied last so a controller set is never lost to a clear
            nxt_status = wByte_ff & `APM_STS_MASK;
        end
    end

    // Wake, override, alarm, sleep button and power button status
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_ff <= `APM_STS_RESET;
        end
        else
        begin
            status_ff <= nxt_status;
        end
    end

    // ------------------------------------------------------------------
    // Enables: host read-write, controller read-only
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_ff <= `APM_EN_RESET;
        end
        else if (hostWr && hostIdx == `APM_IDX_EN_HI)
        begin
            enable_ff <= hostReq.wdata & `APM_EN_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Sleep type and override enable: host only
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleepType_ff <= `APM_SLEEP_TYPE_RESET;
            overrideEnable_ff <= `APM_BIT_RESET;
        end
        else if (hostWr && hostIdx == `APM_IDX_CTL_HI)
        begin
            sleepType_ff <= hostReq.wdata[`APM_SLEEP_TYPE_HI:`APM_SLEEP_TYPE_LO];
            overrideEnable_ff <= hostReq.wdata[`APM_BIT_OVR_EN];
        end
    end

    // ------------------------------------------------------------------
    // Sleep enable: host one sets, controller one clears
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_sleepEnable = sleepEnable_ff;
        if (ecWrOk && ecWrIdx == `APM_IDX_CTL_HI && wByte_ff[`APM_BIT_SLEEP_EN])
        begin
            nxt_sleepEnable = 1'b0;
        end
        // Host set applied last: a new sleep request survives a clear
        if (hostWr && hostIdx == `APM_IDX_CTL_HI && hostReq.wdata[`APM_BIT_SLEEP_EN])
        begin
            nxt_sleepEnable = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleepEnable_ff <= `APM_BIT_RESET;
        end
        else
        begin
            sleepEnable_ff <= nxt_sleepEnable;
        end
    end

    // ------------------------------------------------------------------
    // Host read answer, one cycle after the request
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hostRdData_ff <= 8'h00;
            hostAck_ff <= 1'b0;
        end
        else
        begin
            hostAck_ff <= hostReq.valid && hostHit;
            if (hostRd)
            begin
                hostRdData_ff <= readView(hostIdx, 1'b1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Controller interrupt pulses on host writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ecIrq_ff <= '0;
        end
        else
        begin
            ecIrq_ff.statusWritten <= hostWr && hostIdx == `APM_IDX_STS_HI;
            ecIrq_ff.enableWritten <= hostWr && hostIdx == `APM_IDX_EN_HI;
            ecIrq_ff.controlWritten <= hostWr && hostIdx == `APM_IDX_CTL_HI;
        end
    end

    // ------------------------------------------------------------------
    // AXI write address and data capture, in either order
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awTaken_ff <= 1'b0;
            awAddr_ff <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            awTaken_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
        end
        else if (ecWrFire)
        begin
            awTaken_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wTaken_ff <= 1'b0;
            wByte_ff <= 8'h00;
            wLane_ff <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            wTaken_ff <= 1'b1;
            wByte_ff <= s_axi_wdata[7:0];
            wLane_ff <= s_axi_wstrb[0];
        end
        else if (ecWrFire)
        begin
            wTaken_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // AXI write response
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `APM_RESP_OKAY;
        end
        else if (ecWrFire)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= ecWrMapped ? `APM_RESP_OKAY : `APM_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // AXI read: data registered one cycle after the address
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `APM_RESP_OKAY;
        end
        else if (arFire)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= arMapped ? {24'h00_0000, readView(s_axi_araddr[4:2], 1'b0)}
                                 : 32'h0000_0000;
            rresp_ff <= arMapped ? `APM_RESP_OKAY : `APM_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // One write at a time: new halves wait until the response is taken
    assign s_axi_awready = !awTaken_ff && !bvalid_ff;
    assign s_axi_wready = !wTaken_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign hostRdData = hostRdData_ff;
    assign hostAck = hostAck_ff;
    assign ecIrq = ecIrq_ff;
    assign sleepType = sleepType_ff;
    assign sleepEnable = sleepEnable_ff;
    // Hint for firmware only; the SCI itself stays a firmware decision
    assign eventPending = |(status_ff[2:0] & enable_ff[2:0]);

endmodule : apm_pm1_regs

/* sim/apm_host_agent.sv */
// Host-side bus model for the power-management bank: byte I/O accesses.
// Assumes the host port shares the bank clock.
`timescale 1ns/1ps

module apm_host_agent
    import apm_pkg::*;
(
    // Clock
    input wire logic clk,
    // Host port
    output apm_host_req_t hostReq,
    input wire logic [7:0] hostRdData,
    input wire logic hostAck
);

    // Idle bus until the first access
    initial hostReq = '0;

    // ------------------------------------------------------------
    // One-cycle request, answer sampled mid-cycle after the take edge
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] rd, output logic ok);
        @(posedge clk);
        hostReq <= '{1'b1, w, a, d};
        @(posedge clk);
        // Released lines show inverted junk, not stale values
        hostReq <= '{1'b0, ~w, ~a, ~d};
        @(negedge clk);
        ok = (hostAck === 1'b1);
        rd = hostRdData;
    endtask : xfer

endmodule : apm_host_agent

/* sim/apm_pm1_regs_chk.sv */
// Port-level checker for the power-management bank.
// Assumes it is bound to apm_pm1_regs and sees only its ports.
`timescale 1ns/1ps
`include "apm_defs.svh"

module apm_pm1_regs_chk
    import apm_pkg::*;
#(
    parameter int HOST_ADDR_W = 16,
    parameter int AXI_ADDR_W = 12
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host port
    input wire logic [HOST_ADDR_W-1:0] hostBase,
    input apm_host_req_t hostReq,
    input wire logic hostAck,
    // EC bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Outputs to the chip
    input apm_ec_irq_t ecIrq,
    input wire logic [2:0] sleepType,
    input wire logic sleepEnable
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    logic hit;
    logic wr1;
    logic wr3;
    logic wr5;
    assign hit = hostReq.valid && hostReq.addr[HOST_ADDR_W-1:3] == hostBase[HOST_ADDR_W-1:3];
    assign wr1 = hit && hostReq.write && hostReq.addr[2:0] == 3'h1;
    assign wr3 = hit && hostReq.write && hostReq.addr[2:0] == 3'h3;
    assign wr5 = hit && hostReq.write && hostReq.addr[2:0] == 3'h5;

    // Both write halves taken in one edge
    sequence wrBoth;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    host_ack_a: assert property (hit |=> hostAck)
        else $error("host hit not acknowledged");
    host_miss_a: assert property (!hit |=> !hostAck)
        else $error("acknowledge without a hit");
    irq_status_a: assert property (wr1 |=> ecIrq.statusWritten)
        else $error("status write gave no interrupt");
    irq_cause_a: assert property (ecIrq.enableWritten |-> $past(wr3))
        else $error("enable interrupt without host write");
    type_load_a: assert property (wr5 |=> sleepType == $past(hostReq.wdata[4:2]))
        else $error("sleep type not loaded");
    type_keep_a: assert property (!wr5 |=> $stable(sleepType))
        else $error("sleep type moved without host write");
    sleep_set_a: assert property (wr5 && hostReq.wdata[5] |=> sleepEnable)
        else $error("sleep enable not set");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    rd_slverr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 'h1F
        |=> s_axi_rvalid && s_axi_rresp == `APM_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    wr_resp_a: assert property (wrBoth |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read data dropped before taken");

endmodule : apm_pm1_regs_chk

bind apm_pm1_regs apm_pm1_regs_chk #(.HOST_ADDR_W(HOST_ADDR_W), .AXI_ADDR_W(AXI_ADDR_W)) chk (
    .clk, .rst_n, .hostBase, .hostReq, .hostAck, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ecIrq, .sleepType, .sleepEnable);

/* sim/apm_pm1_regs_tb_top.sv */
// Self-checking bench for the power-management bank.
// Assumes the host agent and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "apm_defs.svh"

module apm_pm1_regs_tb_top;
    import apm_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] hostBase = 16'h0400;
    apm_host_req_t hostReq;
    logic [7:0] hostRdData;
    logic hostAck;
    logic [11:0] awaddr = '0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [11:0] araddr = '0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    apm_ec_irq_t ecIrq;
    logic [2:0] sleepType;
    logic sleepEnable;
    logic eventPending;
    logic [31:0] ecData;
    logic [1:0] ecResp;
    logic [7:0] hrd;
    logic hok;
    int err_count = 0;
    int total_checks = 0;

    always #5 clk = ~clk;

    apm_pm1_regs uut (.clk(clk), .rst_n(rst_n), .hostBase(hostBase), .hostReq(hostReq),
        .hostRdData(hostRdData), .hostAck(hostAck), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ecIrq(ecIrq), .sleepType(sleepType),
        .sleepEnable(sleepEnable), .eventPending(eventPending));

    apm_host_agent host (.clk(clk), .hostReq(hostReq), .hostRdData(hostRdData),
        .hostAck(hostAck));

    // ------------------------------------------------------------
    // Comparison and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // Wait bound ran out: count it and close
    task automatic expire;
        err_count++;
        $display("MISMATCH t=%0t bus wait expired", $time);
        end_of_test();
    endtask : expire

    // ------------------------------------------------------------
    // EC bus master; ready sampled mid-cycle so the take edge is known
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic awP;
        logic wP;
        logic bP;
        int n;
        awP = 1;
        wP = 1;
        bP = 1;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 20 && (awP || wP || bP); n++)
        begin
            @(negedge clk);
            if (awready) awP = 0;
            if (wready) wP = 0;
            if (bvalid) bP = 0;
            ecResp = bresp;
            @(posedge clk);
            if (!awP) awvalid <= 1'b0;
            if (!wP) wvalid <= 1'b0;
            if (!bP) bready <= 1'b0;
        end
        if (bP) expire();
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a);
        logic arP;
        logic rP;
        int n;
        arP = 1;
        rP = 1;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 20 && (arP || rP); n++)
        begin
            @(negedge clk);
            if (arready) arP = 0;
            if (rvalid) rP = 0;
            ecData = rdata;
            ecResp = rresp;
            @(posedge clk);
            if (!arP) arvalid <= 1'b0;
            if (!rP) rready <= 1'b0;
        end
        if (rP) expire();
    endtask : axi_rd

    // Register-level helpers; index times four is the EC byte address
    task automatic ew(input logic [2:0] o, input logic [7:0] d);
        axi_wr({7'h0, o, 2'b00}, {24'h0, d});
        check(ecResp, `APM_RESP_OKAY);
    endtask : ew

    task automatic er(input logic [2:0] o, input logic [7:0] exp);
        axi_rd({7'h0, o, 2'b00});
        check(ecResp, `APM_RESP_OKAY);
        check(ecData, {24'h0, exp});
    endtask : er

    task automatic hw(input logic [2:0] o, input logic [7:0] d);
        host.xfer(1'b1, hostBase + o, d, hrd, hok);
        check(hok, 1'b1);
        // Pulse stands in the cycle after the take edge
        check(ecIrq, {o == `APM_IDX_STS_HI, o == `APM_IDX_EN_HI, o == `APM_IDX_CTL_HI});
    endtask : hw

    task automatic hr(input logic [2:0] o, input logic [7:0] exp);
        host.xfer(1'b0, hostBase + o, 8'h00, hrd, hok);
        check(hok, 1'b1);
        check(hrd, exp);
    endtask : hr

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < `APM_REG_COUNT; i++)
        begin
            er(i[2:0], 8'h00);
            hr(i[2:0], 8'h00);
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_status;
        ew(`APM_IDX_STS_HI, 8'hFF);
        check(ecIrq, 3'h0);
        er(`APM_IDX_STS_HI, `APM_STS_MASK);
        hw(`APM_IDX_STS_HI, 8'h00);
        er(`APM_IDX_STS_HI, 8'h8F);
        hw(`APM_IDX_STS_HI, 8'h01);
        er(`APM_IDX_STS_HI, 8'h8E);
        hw(`APM_IDX_STS_HI, 8'h0E);
        hr(`APM_IDX_STS_HI, 8'h80);
        hw(`APM_IDX_STS_HI, 8'h80);
        er(`APM_IDX_STS_HI, 8'h00);
        ew(`APM_IDX_STS_HI, 8'h06);
        ew(`APM_IDX_STS_HI, 8'h02);
        hr(`APM_IDX_STS_HI, 8'h02);
        $display("test status done");
    endtask : t_status

    task automatic t_enable;
        hw(`APM_IDX_EN_HI, 8'hFF);
        hr(`APM_IDX_EN_HI, `APM_EN_MASK);
        ew(`APM_IDX_EN_HI, 8'h00);
        er(`APM_IDX_EN_HI, 8'h07);
        check(eventPending, 1'b1);
        hw(`APM_IDX_STS_HI, 8'h02);
        check(eventPending, 1'b0);
        $display("test enable done");
    endtask : t_enable

    task automatic t_control;
        hw(`APM_IDX_CTL_HI, 8'hFF);
        er(`APM_IDX_CTL_HI, 8'h3E);
        hr(`APM_IDX_CTL_HI, 8'h1E);
        check(sleepType, 3'h7);
        hw(`APM_IDX_CTL_HI, 8'h0A);
        check(sleepEnable, 1'b1);
        ew(`APM_IDX_CTL_HI, 8'h00);
        er(`APM_IDX_CTL_HI, 8'h2A);
        ew(`APM_IDX_CTL_HI, 8'h20);
        er(`APM_IDX_CTL_HI, 8'h0A);
        $display("test control done");
    endtask : t_control

    task automatic t_decode;
        host.xfer(1'b1, hostBase + 16'h0008, 8'hFF, hrd, hok);
        check(hok, 1'b0);
        hw(`APM_IDX_PM2_HI, 8'hFF);
        hr(`APM_IDX_PM2_HI, 8'h00);
        axi_rd(12'h020);
        check(ecResp, `APM_RESP_SLVERR);
        axi_wr(12'h020, 32'hFF);
        check(ecResp, `APM_RESP_SLVERR);
        // Lane 0 strobe low: write answered but dropped
        wstrb <= 4'hE;
        ew(`APM_IDX_STS_HI, 8'h8F);
        er(`APM_IDX_STS_HI, 8'h00);
        wstrb <= 4'hF;
        $display("test decode done");
    endtask : t_decode

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_status();
        t_enable();
        t_control();
        t_decode();
        end_of_test();
    end

endmodule : apm_pm1_regs_tb_top
